// ===== logic/frt_cfg.svh
`ifndef FRT_CFG_SVH
`define FRT_CFG_SVH

// Register byte addresses on the bus, one aligned word each
`define FRT_OFS_CNT_HI 8'h00
`define FRT_OFS_CNT_LO 8'h04
`define FRT_OFS_ALT_HI 8'h08
`define FRT_OFS_ALT_LO 8'h0c
`define FRT_OFS_CAP1_HI 8'h10
`define FRT_OFS_CAP1_LO 8'h14
`define FRT_OFS_CAP2_HI 8'h18
`define FRT_OFS_CAP2_LO 8'h1c
`define FRT_OFS_CMP1_HI 8'h20
`define FRT_OFS_CMP1_LO 8'h24
`define FRT_OFS_CMP2_HI 8'h28
`define FRT_OFS_CMP2_LO 8'h2c
`define FRT_OFS_STATUS 8'h30
`define FRT_OFS_CTRL1 8'h34
`define FRT_OFS_CTRL2 8'h38

// timer_control_one fields
`define FRT_C1_OVF_IE 7
`define FRT_C1_CAP_IE 6
`define FRT_C1_CMP_IE 5
`define FRT_C1_CAP_EDGE1 4
`define FRT_C1_LVL2 1
`define FRT_C1_LVL1 0
`define FRT_C1_MASK 8'hf3

// timer_control_two fields
`define FRT_C2_PIN_EN1 7
`define FRT_C2_PIN_EN2 6
`define FRT_C2_OPM 5
`define FRT_C2_PWM 4
`define FRT_C2_CLK_HI 3
`define FRT_C2_CLK_LO 2
`define FRT_C2_CAP_EDGE2 1
`define FRT_C2_EXT_EDGE 0

// timer_status_reg fields
`define FRT_ST_CAP1 7
`define FRT_ST_CMP1 6
`define FRT_ST_OVF 5
`define FRT_ST_CAP2 4
`define FRT_ST_CMP2 3

// Reset and preset values
`define FRT_CNT_RESET 16'hfffc
`define FRT_CNT_PRESET 16'hfffc
`define FRT_CNT_TOP 16'hffff
`define FRT_CMP_RESET 16'h8000
`define FRT_CTRL_RESET 8'h00

// log2 of divider for clock select codes 10,01,00 (two bits each)
`define FRT_CLK_DIV_MAP 6'h36
`define FRT_CLK_EXT 2'h3

`endif

// ===== logic/frt_pkg.sv
`default_nettype none
package frt_pkg;

  typedef struct packed {
    logic ovf;
    logic [1:0] cap;
    logic [1:0] cmp;
  } frt_flags_t;

  typedef enum logic {
    FRT_SRC_PRESCALER,
    FRT_SRC_EXTERNAL
  } frt_src_t;

endpackage : frt_pkg
`default_nettype wire

// ===== logic/frt_sync.sv
`default_nettype none
module frt_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);

  logic s1;
  logic s2;
  logic s3;
  logic level;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (ce_i) begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change only when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else if (ce_i) begin
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        rise_o <= s3;
        fall_o <= ~s3;
      end else begin
        rise_o <= 1'b0;
        fall_o <= 1'b0;
      end
    end
  end

endmodule : frt_sync
`default_nettype wire

// ===== logic/frt_timer.sv
// How it works
// RQ1: Counter counts up; wrap from ffff to 0000 sets overflow_flag.
// RQ2: Writing either counter low byte presets the counter to fffc.
// RQ3: Full sequence lasts 65536 ticks times the divider in processor clocks.
// RQ4: High byte read first latches low byte; buffer frozen until low read.
// RQ5: Low byte read outside a sequence returns the live low byte.
// RQ6: Overflow interrupts only with its enable set and global mask clear.
// RQ7: Overflow flag clears by status read then count low access.
// RQ8: Alternate low byte accesses never clear overflow_flag.
// RQ9: Counter runs in wait, stops in halt, reset reloads reset count.
// RQ10: Both select bits one pick the external clock; edge bit picks edge.
// RQ11: All counter updates are synchronous to the processor clock.
// RQ12: External clock must leave four processor clocks between edges.
// RQ13: Selected capture edge copies counter and sets the capture flag.
// RQ14: One capture enable serves both channels, gated by global mask.
// RQ15: Capture flag clears by status read then that low byte access.
// RQ16: Capture high read holds off new transfers until low read.
// RQ17: Capture register always ends with the most recent capture value.
// RQ18: In one-pulse or PWM mode only capture channel two works.
// RQ19: Capture pins always reach the timer; any transition captures. Here only the selected capture edge captures.
// RQ20: Compare values match counter; set flag, drive pin, interrupt.
// RQ21: Compare registers are software only and reset to 8000.
// RQ22: Internal timer clock is processor clock divided by 2, 4 or 8.
// RQ23: Divide by 2 matches counter equal; else counter equals compare plus one.
// RQ24: Clock select code to divider mapping is a parameter.
`include "frt_cfg.svh"
`default_nettype none
module frt_timer #(
  parameter logic [5:0] CLK_DIV_MAP = `FRT_CLK_DIV_MAP
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_timer_clock_pin_i,
  input wire logic [1:0] capture_in_pin_i,
  input wire logic global_irq_mask_i,
  input wire logic halt_i,
  output logic [1:0] compare_out_pin_o,
  output logic [1:0] compare_pin_sel_o,
  output logic irq_o
);

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction : hit

  function automatic logic [2:0] div_last(input logic [1:0] sel, input logic [5:0] map);
    logic [1:0] lg;
    logic [3:0] span;
    lg = map[{sel, 1'b0} +: 2];
    span = 4'h1 << lg;
    return 3'(span - 4'h1);
  endfunction : div_last

  logic [7:0] timer_control_one;
  logic [7:0] timer_control_two;
  logic [15:0] count;
  logic [2:0] presc;
  logic tick;
  logic [1:0] clk_sel;
  frt_pkg::frt_src_t src;
  logic [2:0] presc_last;
  logic div2_mode;
  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  wire logic [1:0] cap_rise;
  wire logic [1:0] cap_fall;
  logic [1:0] cap_edge_sel;
  logic [1:0] cap_evt;
  logic [1:0] cap_allow;
  logic [15:0] cap_val [2];
  logic [15:0] cap_shadow [2];
  logic [1:0] cap_hold;
  logic [1:0] cap_pend;
  logic [15:0] cmp_val [2];
  logic [1:0] cmp_inhibit;
  logic [1:0] cmp_match;
  logic [1:0] cmp_match_q;
  logic [1:0] cmp_evt;
  logic [1:0] cmp_lvl;
  frt_pkg::frt_flags_t flags;
  frt_pkg::frt_flags_t armed;
  frt_pkg::frt_flags_t set_ev;
  frt_pkg::frt_flags_t clr_ev;
  logic [7:0] cnt_buf;
  logic cnt_open;
  logic [7:0] alt_buf;
  logic alt_open;
  logic req;
  logic rd_go;
  logic wr_go;
  logic [7:0] adr;
  logic [7:0] rdata;
  logic [7:0] wdata;
  logic cnt_preset;
  logic [15:0] next_count;

  assign req = wb_cyc_i & wb_stb_i;
  assign adr = wb_adr_i;
  assign wdata = wb_dat_i[7:0];
  // Reads act when the request is taken so data and side effects agree;
  // writes act on the edge where the master samples the acknowledge.
  assign rd_go = req & ~wb_ack_o & ~wb_we_i;
  assign wr_go = req & wb_ack_o & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // Clock source and prescaler
  assign clk_sel = {timer_control_two[`FRT_C2_CLK_HI], timer_control_two[`FRT_C2_CLK_LO]};
  assign src = (clk_sel == `FRT_CLK_EXT) ? frt_pkg::FRT_SRC_EXTERNAL
                                          : frt_pkg::FRT_SRC_PRESCALER; // RQ10
  assign presc_last = div_last(clk_sel, CLK_DIV_MAP); // RQ22 RQ24
  assign div2_mode = (src == frt_pkg::FRT_SRC_PRESCALER) && (presc_last == 3'h1);

  frt_sync u_ext_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(ext_timer_clock_pin_i),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  // Edges arriving faster than four processor clocks may be merged RQ12
  assign ext_edge = timer_control_two[`FRT_C2_EXT_EDGE] ? ext_rise : ext_fall; // RQ10

  always_comb begin
    tick = 1'b0;
    if (!halt_i) begin // RQ9
      unique case (src)
        frt_pkg::FRT_SRC_EXTERNAL: tick = ext_edge; // RQ11
        frt_pkg::FRT_SRC_PRESCALER: tick = (presc == presc_last); // RQ3
      endcase
    end
  end

  assign cnt_preset = wr_go & (hit(adr, `FRT_OFS_CNT_LO) | hit(adr, `FRT_OFS_ALT_LO)); // RQ2

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc <= 3'h0;
    end else if (ce_i) begin
      if (cnt_preset || src == frt_pkg::FRT_SRC_EXTERNAL) begin
        presc <= 3'h0;
      end else if (!halt_i) begin
        presc <= tick ? 3'h0 : presc + 3'h1; // RQ22
      end
    end
  end

  assign next_count = count + 16'h0001;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= `FRT_CNT_RESET; // RQ9
    end else if (ce_i) begin
      if (cnt_preset) begin
        count <= `FRT_CNT_PRESET; // RQ2
      end else if (tick) begin
        count <= next_count; // RQ1
      end
    end
  end

  // Coherent 16-bit reads of both counter views
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_buf <= 8'h00;
      cnt_open <= 1'b0;
      alt_buf <= 8'h00;
      alt_open <= 1'b0;
    end else if (ce_i && rd_go) begin
      if (hit(adr, `FRT_OFS_CNT_HI) && !cnt_open) begin
        cnt_buf <= count[7:0]; // RQ4
        cnt_open <= 1'b1;
      end
      if (hit(adr, `FRT_OFS_CNT_LO)) begin
        cnt_open <= 1'b0; // RQ5
      end
      if (hit(adr, `FRT_OFS_ALT_HI) && !alt_open) begin
        alt_buf <= count[7:0]; // RQ4
        alt_open <= 1'b1;
      end
      if (hit(adr, `FRT_OFS_ALT_LO)) begin
        alt_open <= 1'b0; // RQ5
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_control_one <= `FRT_CTRL_RESET;
      timer_control_two <= `FRT_CTRL_RESET;
    end else if (ce_i && wr_go) begin
      if (hit(adr, `FRT_OFS_CTRL1)) begin
        timer_control_one <= wdata & `FRT_C1_MASK;
      end
      if (hit(adr, `FRT_OFS_CTRL2)) begin
        timer_control_two <= wdata;
      end
    end
  end

  // Input capture
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cap
      frt_sync u_cap_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(capture_in_pin_i[gi]),
        .rise_o(cap_rise[gi]),
        .fall_o(cap_fall[gi])
      );
    end
  endgenerate

  // Pins are wired straight in, so an output-driven toggle also captures RQ19
  assign cap_evt = cap_allow & ((cap_edge_sel & cap_rise) | (~cap_edge_sel & cap_fall)); // RQ13

  assign cap_edge_sel = {timer_control_two[`FRT_C2_CAP_EDGE2],
                         timer_control_one[`FRT_C1_CAP_EDGE1]};
  assign cap_allow = {1'b1, ~(timer_control_two[`FRT_C2_OPM] |
                              timer_control_two[`FRT_C2_PWM])}; // RQ18

  // A held channel parks the newest value in a shadow, overwriting any earlier one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_hold <= 2'h0;
      cap_pend <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        cap_val[i] <= 16'h0000;
        cap_shadow[i] <= 16'h0000;
      end
    end else if (ce_i) begin
      for (int i = 0; i < 2; i++) begin
        if (cap_evt[i]) begin
          if (cap_hold[i]) begin
            cap_shadow[i] <= count; // RQ17
            cap_pend[i] <= 1'b1;
          end else begin
            cap_val[i] <= count; // RQ13
            cap_pend[i] <= 1'b0;
          end
        end else if (!cap_hold[i] && cap_pend[i]) begin
          cap_val[i] <= cap_shadow[i]; // RQ17
          cap_pend[i] <= 1'b0;
        end
      end
      if (rd_go && hit(adr, `FRT_OFS_CAP1_HI)) cap_hold[0] <= 1'b1; // RQ16
      if (rd_go && hit(adr, `FRT_OFS_CAP1_LO)) cap_hold[0] <= 1'b0; // RQ16
      if (rd_go && hit(adr, `FRT_OFS_CAP2_HI)) cap_hold[1] <= 1'b1; // RQ16
      if (rd_go && hit(adr, `FRT_OFS_CAP2_LO)) cap_hold[1] <= 1'b0; // RQ16
    end
  end

  // Output compare registers; a high byte write inhibits matching until low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_val[0] <= `FRT_CMP_RESET; // RQ21
      cmp_val[1] <= `FRT_CMP_RESET; // RQ21
      cmp_inhibit <= 2'h0;
    end else if (ce_i && wr_go) begin
      if (hit(adr, `FRT_OFS_CMP1_HI)) begin
        cmp_val[0][15:8] <= wdata;
        cmp_inhibit[0] <= 1'b1;
      end
      if (hit(adr, `FRT_OFS_CMP1_LO)) begin
        cmp_val[0][7:0] <= wdata;
        cmp_inhibit[0] <= 1'b0;
      end
      if (hit(adr, `FRT_OFS_CMP2_HI)) begin
        cmp_val[1][15:8] <= wdata;
        cmp_inhibit[1] <= 1'b1;
      end
      if (hit(adr, `FRT_OFS_CMP2_LO)) begin
        cmp_val[1][7:0] <= wdata;
        cmp_inhibit[1] <= 1'b0;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cmp_match[i] = ~cmp_inhibit[i] &
                     (count == (div2_mode ? cmp_val[i] : cmp_val[i] + 16'h0001)); // RQ23
    end
  end

  // Flag and pin act once on entry into the match window
  assign cmp_evt = cmp_match & ~cmp_match_q; // RQ20
  assign cmp_lvl = {timer_control_one[`FRT_C1_LVL2], timer_control_one[`FRT_C1_LVL1]};
  assign compare_pin_sel_o = {timer_control_two[`FRT_C2_PIN_EN2],
                              timer_control_two[`FRT_C2_PIN_EN1]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_match_q <= 2'h0;
      compare_out_pin_o <= 2'h0;
    end else if (ce_i) begin
      cmp_match_q <= cmp_match;
      for (int i = 0; i < 2; i++) begin
        if (cmp_evt[i] && compare_pin_sel_o[i]) begin
          compare_out_pin_o[i] <= cmp_lvl[i]; // RQ20
        end
      end
    end
  end

  // Status flags: set wins over the clear step
  always_comb begin
    set_ev.ovf = tick & (count == `FRT_CNT_TOP); // RQ1
    set_ev.cap = cap_evt; // RQ13
    set_ev.cmp = cmp_evt; // RQ20
    clr_ev.ovf = armed.ovf & (rd_go | wr_go) & hit(adr, `FRT_OFS_CNT_LO); // RQ7 RQ8
    clr_ev.cap[0] = armed.cap[0] & (rd_go | wr_go) & hit(adr, `FRT_OFS_CAP1_LO); // RQ15
    clr_ev.cap[1] = armed.cap[1] & (rd_go | wr_go) & hit(adr, `FRT_OFS_CAP2_LO); // RQ15
    clr_ev.cmp[0] = armed.cmp[0] & (rd_go | wr_go) & hit(adr, `FRT_OFS_CMP1_LO);
    clr_ev.cmp[1] = armed.cmp[1] & (rd_go | wr_go) & hit(adr, `FRT_OFS_CMP2_LO);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= '0;
    end else if (ce_i) begin
      flags <= set_ev | (flags & ~clr_ev); // RQ7 RQ15
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed <= '0;
    end else if (ce_i) begin
      if (rd_go && hit(adr, `FRT_OFS_STATUS)) begin
        armed <= flags; // RQ7 RQ15
      end else begin
        armed <= armed & ~clr_ev;
      end
    end
  end

  // A flag stays pending until its enable is set and the mask is clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= ~global_irq_mask_i &
               ((flags.ovf & timer_control_one[`FRT_C1_OVF_IE]) | // RQ6
                ((|flags.cap) & timer_control_one[`FRT_C1_CAP_IE]) | // RQ14
                ((|flags.cmp) & timer_control_one[`FRT_C1_CMP_IE])); // RQ20
    end
  end

  // Read data
  always_comb begin
    rdata = 8'h00;
    unique case ({adr[7:2], 2'b00})
      `FRT_OFS_CNT_HI: rdata = count[15:8];
      `FRT_OFS_CNT_LO: rdata = cnt_open ? cnt_buf : count[7:0]; // RQ4 RQ5
      `FRT_OFS_ALT_HI: rdata = count[15:8];
      `FRT_OFS_ALT_LO: rdata = alt_open ? alt_buf : count[7:0]; // RQ4 RQ5
      `FRT_OFS_CAP1_HI: rdata = cap_val[0][15:8];
      `FRT_OFS_CAP1_LO: rdata = cap_val[0][7:0];
      `FRT_OFS_CAP2_HI: rdata = cap_val[1][15:8];
      `FRT_OFS_CAP2_LO: rdata = cap_val[1][7:0];
      `FRT_OFS_CMP1_HI: rdata = cmp_val[0][15:8];
      `FRT_OFS_CMP1_LO: rdata = cmp_val[0][7:0];
      `FRT_OFS_CMP2_HI: rdata = cmp_val[1][15:8];
      `FRT_OFS_CMP2_LO: rdata = cmp_val[1][7:0];
      `FRT_OFS_STATUS: begin
        rdata[`FRT_ST_CAP1] = flags.cap[0];
        rdata[`FRT_ST_CMP1] = flags.cmp[0];
        rdata[`FRT_ST_OVF] = flags.ovf;
        rdata[`FRT_ST_CAP2] = flags.cap[1];
        rdata[`FRT_ST_CMP2] = flags.cmp[1];
      end
      `FRT_OFS_CTRL1: rdata = timer_control_one;
      `FRT_OFS_CTRL2: rdata = timer_control_two;
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (ce_i && req && !wb_ack_o) begin
      wb_dat_o <= {24'h000000, rdata};
    end
  end

endmodule : frt_timer
`default_nettype wire

// ===== verif/frt_timer_sva.sv
`default_nettype none
module frt_timer_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic global_irq_mask_i,
  input wire logic [1:0] compare_out_pin_o,
  input wire logic [1:0] compare_pin_sel_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic taken;
  logic wr_c2;
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  assign wr_c2 = wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h0e;
  property p_ack_resp; taken |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than a cycle");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(taken); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read lanes not zero");
  // Read data must not drift between requests, or a buffered byte would be lost
  property p_dat_hold; !taken |=> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved while idle");
  property p_unmapped; (taken && !wb_we_i && wb_adr_i[7:2] > 6'h0e) |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_mask; (global_irq_mask_i && ce_i) |=> !irq_o; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
  property p_sel_write; $changed(compare_pin_sel_o) |-> $past(wr_c2) || $past(wr_c2, 2);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("pin ownership moved alone");
  property p_pin_reset;
    disable iff (1'b0) (rst_i && ce_i) |=> compare_out_pin_o == 2'b00 && !irq_o;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pins not low in reset");
  c_irq: cover property ($rose(irq_o));
  c_pin: cover property ($rose(compare_out_pin_o[0]));
  c_wr: cover property (wb_ack_o && wb_we_i);
endmodule : frt_timer_sva
`default_nettype wire

// ===== verif/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ext = 1'b0, mask = 1'b1, halt = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dato;
  logic ack, irq;
  logic [1:0] cap = 2'b00;
  logic [1:0] pin, psel;
  logic [7:0] q;
  logic [15:0] v, w;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  frt_timer uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato),
    .wb_ack_o(ack), .ext_timer_clock_pin_i(ext), .capture_in_pin_i(cap),
    .global_irq_mask_i(mask), .halt_i(halt), .compare_out_pin_o(pin),
    .compare_pin_sel_o(psel), .irq_o(irq));
  always #10 clk_i = ~clk_i;
  task automatic wrap_up;
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Only the global cycle ceiling ends a wait for ack
  task automatic wb(input logic w_en, input logic [3:0] s, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] r);
    cyc <= 1'b1; stb <= 1'b1; we <= w_en; sel <= s; adr <= a; dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dato[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, 4'hf, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    wb(1'b0, 4'hf, a, 8'h00, r);
  endtask : rd
  task automatic rd16(input logic [7:0] a, output logic [15:0] r);
    rd(a, r[15:8]);
    rd(a + 8'h04, r[7:0]);
  endtask : rd16
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  task automatic t_regs;
    rd16(8'h20, v); chk(v, 16'h8000);
    rd16(8'h28, v); chk(v, 16'h8000);
    wr(8'h28, 8'h12); wr(8'h2c, 8'h34); wb(1'b1, 4'h0, 8'h2c, 8'h99, q);
    rd16(8'h28, v); chk(v, 16'h1234);
    wr(8'h3c, 8'hff); rd(8'h3c, q); chk({8'h00, q}, 16'h0000);
  endtask : t_regs
  task automatic t_cap;
    halt <= 1'b1;
    wr(8'h04, 8'h00); rd16(8'h00, v); chk(v, 16'hfffc);
    wr(8'h34, 8'h10); cap <= 2'b01; wt(8);
    rd(8'h30, q); chk({15'h0, q[7]}, 16'h1);
    rd(8'h10, q); chk({8'h00, q}, 16'h00ff);
    halt <= 1'b0; wt(10); halt <= 1'b1;
    // Capture high read holds off the next rising capture until the low read
    cap <= 2'b00; wt(8); rd16(8'h00, w);
    chk({15'h0, w != 16'hfffc}, 16'h1);
    cap <= 2'b01; wt(8);
    rd(8'h14, q); chk({8'h00, q}, 16'h00fc);
    rd16(8'h10, v); chk(v, w);
    rd(8'h30, q); rd(8'h14, q); rd(8'h30, q); chk({15'h0, q[7]}, 16'h0);
    halt <= 1'b0;
  endtask : t_cap
  task automatic t_ovf;
    wr(8'h38, 8'h04); wr(8'h34, 8'h80); wr(8'h04, 8'h00); wt(20);
    rd(8'h30, q); chk({15'h0, q[5]}, 16'h1);
    chk({15'h0, irq}, 16'h0);
    mask <= 1'b0; wt(3); chk({15'h0, irq}, 16'h1);
    rd(8'h0c, q); rd(8'h30, q); rd(8'h0c, q); rd(8'h30, q);
    chk({15'h0, q[5]}, 16'h1);
    rd(8'h04, q); rd(8'h30, q); chk({15'h0, q[5]}, 16'h0);
    wt(3); chk({15'h0, irq}, 16'h0);
    mask <= 1'b1;
  endtask : t_ovf
  task automatic t_div;
    int d;
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 4 : (i == 1) ? 2 : 8;
      wr(8'h38, {4'h0, i[1:0], 2'b00}); wr(8'h04, 8'h00); wt(16 * d); rd(8'h04, q);
      chk({15'h0, (q - 8'h0c) <= 8'h02}, 16'h1);
    end
  endtask : t_div
  task automatic t_buf;
    wr(8'h38, 8'h04);
    rd(8'h00, q); wt(40); rd(8'h00, q); rd(8'h04, v[7:0]); rd(8'h04, w[7:0]);
    q = w[7:0] - v[7:0];
    chk({15'h0, q >= 8'd22 && q <= 8'd27}, 16'h1);
  endtask : t_buf
  task automatic t_cmp;
    int n;
    n = 0;
    wr(8'h34, 8'h01); wr(8'h38, 8'h84); wr(8'h20, 8'h00); wr(8'h24, 8'h10);
    wr(8'h04, 8'h00);
    while (pin[0] !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    chk({15'h0, n >= 38 && n <= 42}, 16'h1);
    chk({14'h0, psel}, 16'h0001);
    rd(8'h30, q); chk({15'h0, q[6]}, 16'h1);
  endtask : t_cmp
  // Edges eight clocks apart keep the external source within its allowed rate
  task automatic t_ext;
    wr(8'h38, 8'h0d); wr(8'h04, 8'h00);
    repeat (5) begin
      ext <= 1'b1; wt(8); ext <= 1'b0; wt(8);
    end
    rd16(8'h00, v); chk(v, 16'h0001);
    wr(8'h38, 8'h0c); wr(8'h04, 8'h00);
    repeat (3) begin
      ext <= 1'b1; wt(8); ext <= 1'b0; wt(8);
    end
    rd16(8'h00, v); chk(v, 16'hffff);
  endtask : t_ext
  // With one-pulse set, channel one ignores its pin while channel two captures
  task automatic t_opm;
    wr(8'h38, 8'h22);
    cap <= 2'b00; wt(8); cap <= 2'b11; wt(8);
    rd(8'h30, q); chk({14'h0, q[7], q[4]}, 16'h0001);
  endtask : t_opm
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs; t_cap; t_ovf; t_div; t_buf; t_cmp; t_ext; t_opm;
    wrap_up;
  end
endmodule : tb
bind frt_timer frt_timer_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .global_irq_mask_i(global_irq_mask_i),
  .compare_out_pin_o(compare_out_pin_o), .compare_pin_sel_o(compare_pin_sel_o),
  .irq_o(irq_o));
`default_nettype wire
